// File: src/diag_history_params.svh
// Offsets, field positions, reset values and codes of the diagnosis history
`ifndef DIAG_HISTORY_PARAMS_SVH
`define DIAG_HISTORY_PARAMS_SVH

// Entry numbers
`define DH_SUB_TOP 8'h00
`define DH_SUB_MAX 8'h01
`define DH_SUB_NEWEST 8'h02
`define DH_SUB_ACKED 8'h03
`define DH_SUB_PEND 8'h04
`define DH_SUB_FLAGS 8'h05
`define DH_FIRST_SLOT 8'h06
`define DH_TOP_SLOT 8'hff

// Ring size
`define DH_MAX_MSGS 8'hfa
`define DH_RING_MOD 9'h0fa
`define DH_RING_LAST 249

// Flag bit positions
`define DH_FLAG_EMCY 0
`define DH_FLAG_NO_INFO 1
`define DH_FLAG_NO_WARN 2
`define DH_FLAG_NO_ERR 3
`define DH_FLAG_MODE 4
`define DH_FLAG_OVR 5
`define DH_FLAGS_RESET 16'h0000

// Abort codes
`define DH_ABORT_LOW 32'h0609_0032
`define DH_ABORT_RANGE 32'h0609_0030
// Access refused while a message is offered, filtered or not
`define DH_ABORT_BUSY 32'h0000_0001

`endif

// File: src/diag_history_pkg.sv
// Types shared by the diagnosis history buffer and its users
package diag_history_pkg;

  typedef enum logic [1:0] {
    SEV_INFO,
    SEV_WARN,
    SEV_ERR,
    SEV_OTHER
  } severity_e;

  typedef struct packed {
    logic write;
    logic [7:0] sub;
    logic [15:0] data;
  } acc_req_s;

  typedef struct packed {
    logic abort;
    logic [31:0] code;
    logic [15:0] data;
  } acc_rsp_s;

  typedef struct packed {
    severity_e severity;
    logic [15:0] code;
  } diag_msg_s;

endpackage : diag_history_pkg

// File: src/diagnosis_history_buffer.sv
// Diagnosis history ring with flags, acknowledge handling and entry access
//
// Summary of operation
// - Flag bit 0 sends stored messages as emergencies
// - Flag bit 1 drops info messages
// - Flag bit 2 drops warning messages
// - Flag bit 3 drops error messages
// - Overwrite mode replaces oldest when full
// - Acknowledge mode overwrites only acknowledged messages
// - Overwrite loss sets bit 5, clears acked
// - Acknowledge mode full, none acked: drop, set bit 5
// - Slots 6 upward, at most 250 messages
// - Full queue wraps back to slot 6
// - Entry 0 gives highest slot number
// - Newest entry: slot 6..255, else 0
// - Overwrite mode zero write clears history and bit 5, keeps bits 0..4
// - Acked write of 1..5 aborts low
// - Overwrite mode stores acked slot without age check
// - Acknowledge mode acked reads 0 or slot
// - Acknowledge mode zero write deletes acknowledged
// - Acked slot write acknowledges it and older
// - Acked write to empty slot aborts range
// - Overwrite mode indicator: newest unread
// - Acknowledge mode indicator: unacknowledged present
`timescale 1ns/100ps
`include "diag_history_params.svh"

module diagnosis_history_buffer (
  input wire logic clock,
  input wire logic nrst,
  input wire logic reqValid,
  input wire diag_history_pkg::acc_req_s req,
  input wire logic msgValid,
  input wire diag_history_pkg::diag_msg_s msg,
  output logic rspValid,
  output diag_history_pkg::acc_rsp_s rsp,
  output logic emcyValid,
  output logic [15:0] emcyCode,
  output logic [15:0] historyFlags,
  output logic newPending
);

  logic [15:0] slotMem [0:`DH_RING_LAST];
  logic [15:0] flags_q;
  logic [7:0] count_q;
  logic [7:0] oldest_q;
  logic [7:0] ackCnt_q;
  logic [7:0] newest_q;
  logic [7:0] newestAcked_q;
  logic unread_q;
  logic rspValid_q;
  diag_history_pkg::acc_rsp_s rsp_q;
  logic emcyValid_q;
  logic [15:0] emcyCode_q;
  logic newPending_q;

  // Ring index arithmetic modulo the ring size
  function automatic logic [7:0] ringAdd(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= `DH_RING_MOD) begin
      s = s - `DH_RING_MOD;
    end
    return s[7:0];
  endfunction : ringAdd

  // Age of a slot counted from the oldest message
  function automatic logic [7:0] slotAge(input logic [7:0] sub, input logic [7:0] oldest);
    logic [8:0] p;
    p = {1'b0, sub - `DH_FIRST_SLOT};
    if (p < {1'b0, oldest}) begin
      p = p + `DH_RING_MOD;
    end
    p = p - {1'b0, oldest};
    return p[7:0];
  endfunction : slotAge

  function automatic logic slotHeld(input logic [7:0] sub, input logic [7:0] oldest,
                                    input logic [7:0] count);
    return (sub >= `DH_FIRST_SLOT) && (slotAge(sub, oldest) < count);
  endfunction : slotHeld

  logic modeAck;
  logic isFull;
  logic blocked;
  logic msgTake;
  logic discard;
  logic store;
  logic evict;
  logic [7:0] wrPtr;
  logic [7:0] wrVal;
  logic accWr;
  logic ackWr;
  logic ackLow;
  logic ackMiss;
  logic ackClear;
  logic ackSet;
  logic [7:0] ackAge;
  logic ackAdvance;
  logic pending;
  logic readNewest;

  assign modeAck = flags_q[`DH_FLAG_MODE];
  assign isFull = (count_q == `DH_MAX_MSGS);

  always_comb begin
    unique case (msg.severity)
      diag_history_pkg::SEV_INFO: blocked = flags_q[`DH_FLAG_NO_INFO];
      diag_history_pkg::SEV_WARN: blocked = flags_q[`DH_FLAG_NO_WARN];
      diag_history_pkg::SEV_ERR: blocked = flags_q[`DH_FLAG_NO_ERR];
      diag_history_pkg::SEV_OTHER: blocked = 1'b0;
    endcase
  end

  assign msgTake = msgValid && !blocked;
  // Full of unacknowledged messages: the newcomer is lost
  assign discard = msgTake && isFull && modeAck && (ackCnt_q == 8'h00);
  assign store = msgTake && !discard;
  assign evict = store && isFull;
  // Full ring wraps onto the oldest slot by the same sum
  assign wrPtr = ringAdd(oldest_q, count_q);

  // Accesses lose against an incoming message; see busy abort
  assign accWr = reqValid && req.write && !msgValid;
  assign wrVal = req.data[7:0];
  assign ackWr = accWr && (req.sub == `DH_SUB_ACKED);
  assign ackLow = ackWr && (wrVal != 8'h00) && (wrVal < `DH_FIRST_SLOT);
  assign ackMiss = ackWr && (wrVal >= `DH_FIRST_SLOT)
                   && !slotHeld(wrVal, oldest_q, count_q);
  assign ackClear = ackWr && (wrVal == 8'h00);
  assign ackSet = ackWr && slotHeld(wrVal, oldest_q, count_q);
  assign ackAge = slotAge(wrVal, oldest_q);
  assign ackAdvance = ackSet && modeAck && ((ackAge + 8'h01) > ackCnt_q);
  assign pending = modeAck ? (count_q > ackCnt_q) : unread_q;
  assign readNewest = reqValid && !req.write && !msgValid
                      && (newest_q != 8'h00) && (req.sub == newest_q);

  // Ring occupancy and acknowledge depth
  always_ff @(posedge clock) begin
    if (!nrst) begin
      count_q <= 8'h00;
      oldest_q <= 8'h00;
      ackCnt_q <= 8'h00;
    end else if (store) begin
      if (evict) begin
        oldest_q <= ringAdd(oldest_q, 8'h01);
        if (modeAck) begin
          ackCnt_q <= ackCnt_q - 8'h01;
        end
      end else begin
        count_q <= count_q + 8'h01;
      end
    end else if (ackClear) begin
      if (modeAck) begin
        count_q <= count_q - ackCnt_q;
        // Emptied history starts again at the first slot
        oldest_q <= (count_q == ackCnt_q) ? 8'h00 : ringAdd(oldest_q, ackCnt_q);
      end else begin
        count_q <= 8'h00;
        oldest_q <= 8'h00;
      end
      ackCnt_q <= 8'h00;
    end else if (ackAdvance) begin
      ackCnt_q <= ackAge + 8'h01;
    end
  end

  // Newest message slot
  always_ff @(posedge clock) begin
    if (!nrst) begin
      newest_q <= 8'h00;
    end else if (store) begin
      newest_q <= wrPtr + `DH_FIRST_SLOT;
    end else if (ackClear && (!modeAck || (count_q == ackCnt_q))) begin
      newest_q <= 8'h00;
    end
  end

  // Newest acknowledged slot
  always_ff @(posedge clock) begin
    if (!nrst) begin
      newestAcked_q <= 8'h00;
    end else if (evict && (!modeAck || (ackCnt_q == 8'h01))) begin
      newestAcked_q <= 8'h00;
    end else if (ackClear) begin
      newestAcked_q <= 8'h00;
    end else if (ackSet && !modeAck) begin
      newestAcked_q <= wrVal;
    end else if (ackAdvance) begin
      newestAcked_q <= wrVal;
    end
  end

  // Newest message still unread
  always_ff @(posedge clock) begin
    if (!nrst) begin
      unread_q <= 1'b0;
    end else if (store) begin
      unread_q <= 1'b1;
    end else if (readNewest || (ackClear && !modeAck)) begin
      unread_q <= 1'b0;
    end
  end

  // Flags: bits 0..4 written, bit 5 set by loss, rest zero
  always_ff @(posedge clock) begin
    if (!nrst) begin
      flags_q <= `DH_FLAGS_RESET;
    end else begin
      if (accWr && (req.sub == `DH_SUB_FLAGS)) begin
        flags_q[`DH_FLAG_MODE:0] <= req.data[`DH_FLAG_MODE:0];
      end
      if (discard || (evict && !modeAck)) begin
        flags_q[`DH_FLAG_OVR] <= 1'b1;
      end else if (ackClear && !modeAck) begin
        flags_q[`DH_FLAG_OVR] <= 1'b0;
      end
    end
  end

  // Message storage; no reset needed for contents
  always_ff @(posedge clock) begin
    if (store) begin
      slotMem[wrPtr] <= msg.code;
    end
  end

  // Access answers, one cycle after the request
  always_ff @(posedge clock) begin
    if (!nrst) begin
      rspValid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      rspValid_q <= reqValid;
      rsp_q <= '0;
      if (reqValid && msgValid) begin
        rsp_q.abort <= 1'b1;
        rsp_q.code <= `DH_ABORT_BUSY;
      end else if (ackLow) begin
        rsp_q.abort <= 1'b1;
        rsp_q.code <= `DH_ABORT_LOW;
      end else if (ackMiss) begin
        rsp_q.abort <= 1'b1;
        rsp_q.code <= `DH_ABORT_RANGE;
      end else if (reqValid && !req.write) begin
        unique case (req.sub)
          `DH_SUB_TOP: rsp_q.data <= {8'h00, `DH_TOP_SLOT};
          `DH_SUB_MAX: rsp_q.data <= {8'h00, `DH_MAX_MSGS};
          `DH_SUB_NEWEST: rsp_q.data <= {8'h00, newest_q};
          `DH_SUB_ACKED: rsp_q.data <= {8'h00, newestAcked_q};
          `DH_SUB_PEND: rsp_q.data <= {15'h0000, pending};
          `DH_SUB_FLAGS: rsp_q.data <= flags_q;
          default: begin
            if (slotHeld(req.sub, oldest_q, count_q)) begin
              rsp_q.data <= slotMem[req.sub - `DH_FIRST_SLOT];
            end
          end
        endcase
      end
    end
  end

  // Emergency copy of each stored message
  always_ff @(posedge clock) begin
    if (!nrst) begin
      emcyValid_q <= 1'b0;
      emcyCode_q <= 16'h0000;
    end else begin
      emcyValid_q <= store && flags_q[`DH_FLAG_EMCY];
      if (store) begin
        emcyCode_q <= msg.code;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      newPending_q <= 1'b0;
    end else begin
      newPending_q <= pending;
    end
  end

  assign rspValid = rspValid_q;
  assign rsp = rsp_q;
  assign emcyValid = emcyValid_q;
  assign emcyCode = emcyCode_q;
  assign historyFlags = flags_q;
  assign newPending = newPending_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  sequence s_zero_write_ovw;
    ackClear && !modeAck;
  endsequence

  sequence s_all_cleared;
    (count_q == 8'h00) && (newest_q == 8'h00) && (newestAcked_q == 8'h00)
      && !flags_q[`DH_FLAG_OVR] && !unread_q;
  endsequence

  sequence s_low_write;
    accWr && (req.sub == `DH_SUB_ACKED) && (req.data[7:0] >= 8'h01)
      && (req.data[7:0] <= 8'h05);
  endsequence

  a_emcy_follow: assert property (
    store && flags_q[`DH_FLAG_EMCY] |=> emcyValid)
    else $error("emergency pulse does not match stored message");

  a_emcy_quiet: assert property (
    !(store && flags_q[`DH_FLAG_EMCY]) |=> !emcyValid)
    else $error("emergency pulse without enabled store");

  a_filter_drop: assert property (
    msgValid && blocked |=> $stable(count_q) && $stable(newest_q))
    else $error("filtered message changed the history");

  a_overrun_mark: assert property (
    evict && !modeAck |=> flags_q[`DH_FLAG_OVR] && (newestAcked_q == 8'h00))
    else $error("overwrite loss not reported");

  a_discard_mark: assert property (
    discard |=> flags_q[`DH_FLAG_OVR] && $stable(count_q) && $stable(newest_q))
    else $error("discard in acknowledge mode not handled");

  a_count_bound: assert property (
    count_q <= `DH_MAX_MSGS)
    else $error("history holds more than the maximum");

  a_wrap_slot: assert property (
    store |=> (newest_q >= `DH_FIRST_SLOT) && (newest_q == $past(wrPtr) + `DH_FIRST_SLOT))
    else $error("message not stored in next ring slot");

  a_newest_empty: assert property (
    (count_q == 8'h00) == (newest_q == 8'h00))
    else $error("newest entry disagrees with occupancy");

  a_clear_all: assert property (
    s_zero_write_ovw |=> s_all_cleared)
    else $error("zero write did not clear the history");

  a_abort_low: assert property (
    s_low_write |=> rspValid && rsp.abort && (rsp.code == `DH_ABORT_LOW))
    else $error("low acknowledge value not aborted");

  a_abort_miss: assert property (
    ackMiss |=> rspValid && rsp.abort && (rsp.code == `DH_ABORT_RANGE))
    else $error("empty slot acknowledge not aborted");

  a_ack_bound: assert property (
    ackCnt_q <= count_q)
    else $error("acknowledged depth exceeds occupancy");

  a_rsvd_flags: assert property (
    flags_q[15:6] == 10'h000)
    else $error("reserved flag bits set");

  a_ovr_keep: assert property (
    accWr && (req.sub == `DH_SUB_FLAGS) |=> $stable(flags_q[`DH_FLAG_OVR]))
    else $error("flags write changed the overrun bit");

  a_unread_set: assert property (
    store && !modeAck |=> unread_q)
    else $error("stored message not marked unread");

  a_read_clears: assert property (
    readNewest |=> !unread_q)
    else $error("reading newest slot left it unread");

  a_zero_ack: assert property (
    ackClear && modeAck |=> (newestAcked_q == 8'h00) && (ackCnt_q == 8'h00))
    else $error("zero write kept acknowledged messages");

endmodule : diagnosis_history_buffer

// File: verification/fieldbus_master_model.sv
// Fieldbus master model issuing entry accesses
`timescale 1ns/100ps
module fieldbus_master_model (
  input wire logic clock,
  output logic reqValid,
  output diag_history_pkg::acc_req_s req,
  input wire logic rspValid,
  input wire diag_history_pkg::acc_rsp_s rsp
);
  initial begin
    reqValid = 1'b0;
    req = '0;
  end

  task automatic access(input logic wr, input logic [7:0] sub, input logic [15:0] dat,
      output diag_history_pkg::acc_rsp_s got);
    @(posedge clock);
    #1;
    reqValid = 1'b1;
    req = {wr, sub, dat};
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    // Released bus shows no stale request
    req = {~wr, ~sub, ~dat};
    got = rspValid === 1'b1 ? rsp : 'x;
  endtask : access
endmodule : fieldbus_master_model

// File: verification/diagnosis_history_buffer_tb.sv
// Self-checking bench for the diagnosis history buffer
`timescale 1ns/100ps
module diagnosis_history_buffer_tb;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic msgValid = 1'b0;
  diag_history_pkg::diag_msg_s msg = '0;
  logic reqValid, rspValid, emcyValid, newPending, emcySeen;
  diag_history_pkg::acc_req_s req;
  diag_history_pkg::acc_rsp_s rsp, got;
  logic [15:0] emcyCode, historyFlags;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;

  always #5 clock = ~clock;

  diagnosis_history_buffer diagnosis_history_buffer_i (.clock(clock), .nrst(nrst),
    .reqValid(reqValid), .req(req), .msgValid(msgValid), .msg(msg), .rspValid(rspValid),
    .rsp(rsp), .emcyValid(emcyValid), .emcyCode(emcyCode), .historyFlags(historyFlags),
    .newPending(newPending));
  fieldbus_master_model fieldbus_master_model_i (.clock(clock), .reqValid(reqValid),
    .req(req), .rspValid(rspValid), .rsp(rsp));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [7:0] sub, input logic [15:0] exp);
    fieldbus_master_model_i.access(1'b0, sub, 16'h0000, got);
    chk("read data", {16'h0000, exp}, {16'h0000, got.data});
  endtask : rd

  task automatic wr(input logic [7:0] sub, input logic [15:0] dat, input logic [31:0] code);
    fieldbus_master_model_i.access(1'b1, sub, dat, got);
    chk("abort code", code, got.code);
    chk("abort flag", {31'h0, code != 32'h0}, {31'h0, got.abort});
  endtask : wr

  task automatic send(input logic [1:0] sev, input logic [15:0] code);
    @(posedge clock);
    #1;
    msgValid = 1'b1;
    msg = {sev, code};
    @(posedge clock);
    #1;
    msgValid = 1'b0;
    emcySeen = emcyValid;
  endtask : send

  // Indicator is registered one cycle behind the stored state
  task automatic pend(input logic exp);
    @(posedge clock);
    #1;
    chk("newPending", {31'h0, exp}, {31'h0, newPending});
  endtask : pend

  task automatic results;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      error_cnt++;
      results();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    #1;
    nrst = 1'b1;
    rd(8'h00, 16'h00ff);
    rd(8'h01, 16'h00fa);
    rd(8'h02, 16'h0000);
    rd(8'h03, 16'h0000);
    rd(8'h05, 16'h0000);
    $display("test reset done");
    send(2'd0, 16'h1111);
    rd(8'h02, 16'h0006);
    pend(1'b1);
    rd(8'h06, 16'h1111);
    pend(1'b0);
    for (int i = 1; i < 4; i++) begin
      wr(8'h05, 16'h0001 << i, 32'h0);
      send(i[1:0] - 2'd1, 16'h2222);
      rd(8'h02, 16'h0006);
    end
    send(2'd3, 16'h3333);
    rd(8'h02, 16'h0007);
    wr(8'h05, 16'h0001, 32'h0);
    send(2'd0, 16'habcd);
    chk("emcyValid", 32'h1, {31'h0, emcySeen});
    chk("emcyCode", 32'habcd, {16'h0, emcyCode});
    wr(8'h05, 16'hffe0, 32'h0);
    send(2'd0, 16'h4444);
    chk("emcyValid", 32'h0, {31'h0, emcySeen});
    chk("historyFlags", 32'h0, {16'h0, historyFlags});
    $display("test filter done");
    wr(8'h03, 16'h0001, 32'h0609_0032);
    wr(8'h03, 16'h0005, 32'h0609_0032);
    wr(8'h03, 16'h00c8, 32'h0609_0030);
    wr(8'h03, 16'h0007, 32'h0);
    rd(8'h03, 16'h0007);
    wr(8'h03, 16'h0000, 32'h0);
    rd(8'h02, 16'h0000);
    for (int i = 0; i < 250; i++) send(2'd1, i[15:0]);
    rd(8'h02, 16'h00ff);
    wr(8'h03, 16'h0007, 32'h0);
    send(2'd1, 16'h00fa);
    rd(8'h02, 16'h0006);
    rd(8'h06, 16'h00fa);
    rd(8'h07, 16'h0001);
    rd(8'h05, 16'h0020);
    rd(8'h03, 16'h0000);
    wr(8'h03, 16'h0000, 32'h0);
    rd(8'h05, 16'h0000);
    rd(8'h04, 16'h0000);
    $display("test overwrite done");
    wr(8'h05, 16'h0010, 32'h0);
    rd(8'h03, 16'h0000);
    for (int i = 0; i < 250; i++) send(2'd2, i[15:0]);
    send(2'd2, 16'h5555);
    rd(8'h02, 16'h00ff);
    rd(8'h05, 16'h0030);
    pend(1'b1);
    wr(8'h03, 16'h000a, 32'h0);
    rd(8'h03, 16'h000a);
    send(2'd2, 16'h6666);
    rd(8'h02, 16'h0006);
    rd(8'h06, 16'h6666);
    wr(8'h03, 16'h0000, 32'h0);
    rd(8'h08, 16'h0000);
    wr(8'h03, 16'h0008, 32'h0609_0030);
    wr(8'h03, 16'h0006, 32'h0);
    pend(1'b0);
    $display("test acknowledge done");
    results();
  end
endmodule : diagnosis_history_buffer_tb
